//--- pkg/e1_irq_pkg.sv
// Constants and carriers for the E1 block interrupt summary and FCS error counter
package e1_irq_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int AXI_ADDR_W = 14;
  localparam int IDX_W = 12;
  localparam int SRC_NUM = 12;

  // ==========================================================================
  // Register indices; the byte address is four times the index
  localparam logic [11:0] IDX_CLK_CFG = 12'h100;
  localparam logic [11:0] IDX_FCS3_COUNT = 12'h92C;
  localparam logic [11:0] IDX_SUMMARY = 12'hB00;
  localparam logic [11:0] IDX_BLOCK_ENABLE = 12'hB01;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'hB81;
  // Source status: spare bit6, six data-link, slip, three alarm, framer
  localparam logic [11:0] IDX_SRC_STATUS [SRC_NUM] = '{
    12'hB0C, 12'hB06, 12'hB16, 12'hB26, 12'hB10, 12'hB18, 12'hB28,
    12'hB08, 12'hB02, 12'hB0E, 12'hB40, 12'hB04};
  localparam logic [11:0] IDX_SRC_ENABLE [SRC_NUM] = '{
    12'hB0D, 12'hB07, 12'hB17, 12'hB27, 12'hB11, 12'hB19, 12'hB29,
    12'hB09, 12'hB03, 12'hB0F, 12'hB41, 12'hB05};

  // ==========================================================================
  // Summary bit positions, clock loss detect enable bit and source groups
  localparam int BIT_SPARE6 = 7;
  localparam int BIT_CLK_LOSS = 5;
  localparam int BIT_ONE_SEC = 4;
  localparam int BIT_HDLC = 3;
  localparam int BIT_SLIP = 2;
  localparam int BIT_ALARM = 1;
  localparam int BIT_FRAMER = 0;
  localparam int BIT_CLK_DETECT_EN = 0;
  localparam int SRC_SPARE6 = 0;
  localparam int SRC_HDLC_FIRST = 1;
  localparam int SRC_HDLC_LAST = 6;
  localparam int SRC_SLIP = 7;
  localparam int SRC_ALARM_FIRST = 8;
  localparam int SRC_ALARM_LAST = 10;
  localparam int SRC_FRAMER = 11;

  // ==========================================================================
  // Values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] FCS_ONE = 8'h01;
  localparam logic [7:0] FCS_MAX = 8'hFF;
  localparam logic [7:0] ENABLE_WRITE_MASK = 8'hBF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Carriers
  typedef logic [SRC_NUM-1:0][7:0] src_byte_type;

  typedef struct packed {
    logic awvalid;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_ADDR_W-1:0] araddr;
    logic rready;
  } axil_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_type;

endpackage : e1_irq_pkg

//--- design/e1_block_irq_status_fcs_count.sv
// Block interrupt summary, source flags, FCS error counter and AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Count each FCS error of the third data-link receiver in eight bits.
// - Reading the counter returns the count since last read, then zeroes it.
// - Summary bit 7 is high while the spare bit6 block has pending requests.
// - Reading the spare bit6 source status register clears that request.
// - Summary bit 5 shows a clock loss event since the last summary read.
// - Clock loss summary can only set when clock loss detection is enabled.
// - Summary bit 4 shows a one-second tick since the last summary read.
// - Summary bit 3 is high while any data-link controller has a request.
// - Reading the six data-link status registers clears their requests.
// - Summary bit 2 follows slip requests, cleared by reading slip status.
// - Summary bit 1 follows alarm requests, cleared by reading alarm status.
// - Summary bit 0 follows framer requests, cleared by reading framer status.
// - Block enables and source enables both gate interrupts to the pin.
module e1_block_irq_status_fcs_count
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Register bus
  input wire e1_irq_pkg::axil_req_type i_axi,
  output var e1_irq_pkg::axil_rsp_type o_axi,
  // Sub-block events, one-cycle pulses
  input wire e1_irq_pkg::src_byte_type i_src_event,
  input wire logic i_fcs_error_ctrl3,
  input wire logic i_clock_loss_event,
  input wire logic i_one_second_tick,
  // Interrupt pin
  output logic o_irq
);
  import e1_irq_pkg::*;

  // ==========================================================================
  // State
  logic aw_held;
  logic w_held;
  logic [IDX_W-1:0] aw_idx;
  logic [7:0] w_byte;
  logic w_lane0;
  logic [7:0] fcs_count;
  src_byte_type src_flag;
  src_byte_type src_enable;
  logic [7:0] block_enable;
  logic clk_detect_en;
  logic clk_sticky;
  logic sec_sticky;
  logic [7:0] irq_status;
  logic [7:0] summary_prev;

  logic next_aw_held;
  logic next_w_held;
  logic [IDX_W-1:0] next_aw_idx;
  logic [7:0] next_w_byte;
  logic next_w_lane0;
  axil_rsp_type next_rsp;
  logic [7:0] next_fcs_count;
  src_byte_type next_src_flag;
  src_byte_type next_src_enable;
  logic [7:0] next_block_enable;
  logic next_clk_detect_en;
  logic next_clk_sticky;
  logic next_sec_sticky;
  logic [7:0] next_irq_status;
  logic next_irq;

  // Decoded terms
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_go;
  logic wr_ok;
  logic wr_en;
  logic rd_ok;
  logic [7:0] rd_data;
  logic [IDX_W-1:0] rd_idx;
  logic [SRC_NUM-1:0] rd_src_hit;
  logic [SRC_NUM-1:0] wr_src_en_hit;
  logic [SRC_NUM-1:0] pend;
  logic [7:0] summary;
  logic rd_fcs;
  logic rd_sum;

  // ==========================================================================
  // Summary: bits 7 and 3-0 are the OR of their sub-block's enabled pending flags; bits 5 and 4 are sticky
  always_comb
  begin
    for (int k = 0; k < SRC_NUM; k++)
    begin
      pend[k] = |(src_flag[k] & src_enable[k]);
    end
    summary = RESET_BYTE;
    summary[BIT_SPARE6] = pend[SRC_SPARE6];
    summary[BIT_CLK_LOSS] = clk_sticky;
    summary[BIT_ONE_SEC] = sec_sticky;
    summary[BIT_HDLC] = |pend[SRC_HDLC_LAST:SRC_HDLC_FIRST];
    summary[BIT_SLIP] = pend[SRC_SLIP];
    summary[BIT_ALARM] = |pend[SRC_ALARM_LAST:SRC_ALARM_FIRST];
    summary[BIT_FRAMER] = pend[SRC_FRAMER];
  end

  // ==========================================================================
  // Address decode for reads (live address) and writes (latched address)
  always_comb
  begin
    aw_hs = i_axi.awvalid & o_axi.awready;
    w_hs = i_axi.wvalid & o_axi.wready;
    ar_hs = i_axi.arvalid & o_axi.arready;
    wr_go = aw_held & w_held & ~o_axi.bvalid;
    rd_idx = i_axi.araddr[AXI_ADDR_W-1:2];
    rd_ok = 1'b1;
    rd_data = RESET_BYTE;
    rd_src_hit = '0;
    wr_src_en_hit = '0;
    case (rd_idx)
      IDX_FCS3_COUNT: rd_data = fcs_count;
      IDX_SUMMARY: rd_data = summary;
      IDX_BLOCK_ENABLE: rd_data = block_enable;
      IDX_CLK_CFG: rd_data = {7'h00, clk_detect_en};
      IDX_IRQ_STATUS: rd_data = irq_status;
      default: rd_ok = 1'b0;
    endcase
    // Summary and counter are read-only: a write is answered but changes nothing
    case (aw_idx)
      IDX_FCS3_COUNT, IDX_SUMMARY, IDX_BLOCK_ENABLE, IDX_CLK_CFG, IDX_IRQ_STATUS:
        wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
    for (int k = 0; k < SRC_NUM; k++)
    begin
      if (rd_idx == IDX_SRC_STATUS[k])
      begin
        rd_ok = 1'b1;
        rd_data = src_flag[k];
        rd_src_hit[k] = ar_hs;
      end
      if (rd_idx == IDX_SRC_ENABLE[k])
      begin
        rd_ok = 1'b1;
        rd_data = src_enable[k];
      end
      if (aw_idx == IDX_SRC_STATUS[k])
      begin
        wr_ok = 1'b1;
      end
      if (aw_idx == IDX_SRC_ENABLE[k])
      begin
        wr_ok = 1'b1;
        wr_src_en_hit[k] = 1'b1;
      end
    end
    wr_en = wr_go & w_lane0;
    rd_fcs = ar_hs && (rd_idx == IDX_FCS3_COUNT);
    rd_sum = ar_hs && (rd_idx == IDX_SUMMARY);
  end

  // ==========================================================================
  // Bus handshake: address and data in either order, one write and one read
  always_comb
  begin
    next_rsp = o_axi;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_idx = aw_idx;
    next_w_byte = w_byte;
    next_w_lane0 = w_lane0;
    if (aw_hs)
    begin
      next_aw_held = 1'b1;
      next_aw_idx = i_axi.awaddr[AXI_ADDR_W-1:2];
    end
    if (w_hs)
    begin
      next_w_held = 1'b1;
      next_w_byte = i_axi.wdata[7:0];
      next_w_lane0 = i_axi.wstrb[0];
    end
    if (o_axi.bvalid && i_axi.bready)
    begin
      next_rsp.bvalid = 1'b0;
    end
    if (wr_go)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_rsp.bvalid = 1'b1;
      next_rsp.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // Readies stay low until the response is taken, so one write is in flight
    next_rsp.awready = ~next_aw_held & ~next_rsp.bvalid;
    next_rsp.wready = ~next_w_held & ~next_rsp.bvalid;
    if (o_axi.rvalid && i_axi.rready)
    begin
      next_rsp.rvalid = 1'b0;
    end
    if (ar_hs)
    begin
      next_rsp.rvalid = 1'b1;
      next_rsp.rdata = {24'h000000, rd_data};
      next_rsp.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    next_rsp.arready = ~next_rsp.rvalid;
  end

  // ==========================================================================
  // Register state: counters, sticky flags, enables; a set always beats a clear
  always_comb
  begin
    next_fcs_count = fcs_count;
    if (rd_fcs)
    begin
      next_fcs_count = i_fcs_error_ctrl3 ? FCS_ONE : RESET_BYTE;
    end
    else if (i_fcs_error_ctrl3 && (fcs_count != FCS_MAX))
    begin
      next_fcs_count = fcs_count + FCS_ONE;
    end
    for (int k = 0; k < SRC_NUM; k++)
    begin
      // Source reads clear flags; an event in the same cycle survives
      next_src_flag[k] = (src_flag[k] & ~{8{rd_src_hit[k]}}) | i_src_event[k];
      next_src_enable[k] = (wr_en && wr_src_en_hit[k]) ? w_byte : src_enable[k];
    end
    next_block_enable = block_enable;
    next_clk_detect_en = clk_detect_en;
    if (wr_en && (aw_idx == IDX_BLOCK_ENABLE))
    begin
      next_block_enable = w_byte & ENABLE_WRITE_MASK;
    end
    if (wr_en && (aw_idx == IDX_CLK_CFG))
    begin
      next_clk_detect_en = w_byte[BIT_CLK_DETECT_EN];
    end
    // Clock loss needs detection and its enable; the summary read clears it
    next_clk_sticky = (clk_sticky & ~rd_sum)
      | (i_clock_loss_event & clk_detect_en & block_enable[BIT_CLK_LOSS]);
    next_sec_sticky = (sec_sticky & ~rd_sum)
      | (i_one_second_tick & block_enable[BIT_ONE_SEC]);
    // Interrupt status catches each summary rise; written ones clear it
    next_irq_status = irq_status;
    if (wr_en && (aw_idx == IDX_IRQ_STATUS))
    begin
      next_irq_status = irq_status & ~w_byte;
    end
    next_irq_status = next_irq_status | (summary & ~summary_prev);
    next_irq = |(irq_status & block_enable);
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_axi <= '0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= '0;
      w_byte <= RESET_BYTE;
      w_lane0 <= 1'b0;
      fcs_count <= RESET_BYTE;
      src_flag <= '0;
      src_enable <= '0;
      block_enable <= RESET_BYTE;
      clk_detect_en <= 1'b0;
      clk_sticky <= 1'b0;
      sec_sticky <= 1'b0;
      irq_status <= RESET_BYTE;
      summary_prev <= RESET_BYTE;
      o_irq <= 1'b0;
    end
    else
    begin
      o_axi <= next_rsp;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_idx <= next_aw_idx;
      w_byte <= next_w_byte;
      w_lane0 <= next_w_lane0;
      fcs_count <= next_fcs_count;
      src_flag <= next_src_flag;
      src_enable <= next_src_enable;
      block_enable <= next_block_enable;
      clk_detect_en <= next_clk_detect_en;
      clk_sticky <= next_clk_sticky;
      sec_sticky <= next_sec_sticky;
      irq_status <= next_irq_status;
      summary_prev <= summary;
      o_irq <= next_irq;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  fcs_count_step_a: assert property (
    (i_fcs_error_ctrl3 && !rd_fcs && fcs_count != FCS_MAX)
      |=> fcs_count == $past(fcs_count) + FCS_ONE)
    else $error("FCS counter did not step on an error");

  fcs_read_clear_a: assert property (
    (rd_fcs && !i_fcs_error_ctrl3) |=> (fcs_count == RESET_BYTE) && o_axi.rvalid
      && (o_axi.rdata[7:0] == $past(fcs_count)))
    else $error("FCS read did not return and clear the count");

  fcs_saturate_a: assert property (
    (fcs_count == FCS_MAX && !rd_fcs) |=> fcs_count == FCS_MAX)
    else $error("FCS counter wrapped");

  spare6_summary_a: assert property (
    (|(i_src_event[SRC_SPARE6] & src_enable[SRC_SPARE6])
      && !(wr_en && wr_src_en_hit[SRC_SPARE6])) |=> summary[BIT_SPARE6])
    else $error("Spare bit6 request did not reach the summary");

  source_read_clear_a: assert property (
    (rd_src_hit[SRC_SPARE6] && i_src_event[SRC_SPARE6] == 8'h00)
      |=> !summary[BIT_SPARE6])
    else $error("Spare bit6 source read did not clear the summary");

  hdlc_read_clear_a: assert property (
    (rd_src_hit[SRC_HDLC_FIRST] && i_src_event[SRC_HDLC_FIRST] == 8'h00)
      |=> src_flag[SRC_HDLC_FIRST] == 8'h00)
    else $error("Data-link status read did not clear its flags");

  clk_loss_gate_a: assert property (
    (!clk_detect_en && !clk_sticky) |=> !clk_sticky)
    else $error("Clock loss flag set with detection disabled");

  summary_read_a: assert property (
    (rd_sum && !i_clock_loss_event && !i_one_second_tick)
      |=> !summary[BIT_CLK_LOSS] && !summary[BIT_ONE_SEC])
    else $error("Summary read left a since-last-read bit set");

  irq_pin_a: assert property (
    ((irq_status & block_enable) != 8'h00) |=> o_irq)
    else $error("Enabled pending interrupt did not reach the pin");

  irq_quiet_a: assert property (
    ((irq_status & block_enable) == 8'h00) |=> !o_irq)
    else $error("Interrupt pin high with nothing enabled pending");

  read_answer_a: assert property (ar_hs |=> o_axi.rvalid && !o_axi.arready)
    else $error("Read not answered one cycle after acceptance");

  fcs_read_cov: cover property (rd_fcs && fcs_count != RESET_BYTE);
  irq_raise_cov: cover property (!o_irq ##1 o_irq);
  write_resp_cov: cover property (wr_go ##1 o_axi.bvalid && i_axi.bready);

endmodule : e1_block_irq_status_fcs_count

`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the E1 block interrupt summary and FCS counter
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
  $display("BAD %s expected %h seen %h", what, exp, got); end end
module tb_top;
  import e1_irq_pkg::*;
  // ==========================================================================
  // Stimulus, notes and counters
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  axil_req_type req = '0;
  axil_rsp_type rsp;
  src_byte_type src_ev = '0;
  logic fcs_err = 1'b0;
  logic clk_loss = 1'b0;
  logic one_sec = 1'b0;
  logic irq;
  int fail_count = 0;
  int checks_done = 0;
  logic [33:0] exp_r [$];
  logic [1:0] exp_b [$];
  logic [7:0] val;
  int n;

  // 100 MHz clock
  always #5 i_clk = ~i_clk;

  e1_block_irq_status_fcs_count dut
  (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_axi(req),
    .o_axi(rsp),
    .i_src_event(src_ev),
    .i_fcs_error_ctrl3(fcs_err),
    .i_clock_loss_event(clk_loss),
    .i_one_second_tick(one_sec),
    .o_irq(irq)
  );

  // ==========================================================================
  // Monitor: each response is matched with the oldest note, in issue order
  always @(posedge i_clk)
  begin
    if (rsp.rvalid && req.rready)
    begin
      `CHK("rdata", exp_r[0][31:0], rsp.rdata)
      `CHK("rresp", exp_r[0][33:32], rsp.rresp)
      void'(exp_r.pop_front());
    end
    if (rsp.bvalid && req.bready)
    begin
      `CHK("bresp", exp_b[0], rsp.bresp)
      void'(exp_b.pop_front());
    end
  end

  // ==========================================================================
  // Bus tasks; each starts on a fresh edge so no signal is driven twice in one step
  task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] r,
    input logic [3:0] s = 4'hF);
    int k = 0;
    exp_b.push_back(r);
    @(posedge i_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= {idx, 2'b00};
    req.wvalid <= 1'b1;
    req.wdata <= {24'h000000, d};
    req.wstrb <= s;
    req.bready <= 1'b1;
    do
    begin
      @(posedge i_clk);
      k++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end
    while (!(rsp.bvalid && req.bready) && k < 50);
    req.bready <= 1'b0;
    if (k >= 50) fail_count++;
  endtask : wr

  task automatic rd(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] r);
    int k = 0;
    exp_r.push_back({r, 24'h000000, d});
    @(posedge i_clk);
    req.arvalid <= 1'b1;
    req.araddr <= {idx, 2'b00};
    req.rready <= 1'b1;
    do
    begin
      @(posedge i_clk);
      k++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end
    while (!(rsp.rvalid && req.rready) && k < 50);
    req.rready <= 1'b0;
    if (k >= 50) fail_count++;
  endtask : rd

  // One-cycle pulse on the clock loss and one-second inputs
  task automatic pulse(input logic cl, input logic os);
    @(posedge i_clk);
    clk_loss <= cl;
    one_sec <= os;
    @(posedge i_clk);
    clk_loss <= 1'b0;
    one_sec <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask : pulse

  // Summary bit that a source index feeds
  function automatic int grp(input int s);
    if (s == SRC_SPARE6) return BIT_SPARE6;
    if (s <= SRC_HDLC_LAST) return BIT_HDLC;
    if (s == SRC_SLIP) return BIT_SLIP;
    if (s <= SRC_ALARM_LAST) return BIT_ALARM;
    return BIT_FRAMER;
  endfunction : grp

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // ==========================================================================
  // Watchdog: the sequence needs roughly seven hundred cycles
  initial
  begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    summarize();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    n = $urandom(32'hDF27FE14);
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    // Reset values, unmapped place, write to the read-only summary
    rd(IDX_FCS3_COUNT, 8'h00, RESP_OKAY);
    rd(IDX_SUMMARY, 8'h00, RESP_OKAY);
    rd(IDX_BLOCK_ENABLE, 8'h00, RESP_OKAY);
    rd(12'h000, 8'h00, RESP_SLVERR);
    wr(12'h000, 8'h5A, RESP_SLVERR);
    wr(IDX_SUMMARY, 8'hFF, RESP_OKAY);
    rd(IDX_SUMMARY, 8'h00, RESP_OKAY);
    wr(IDX_BLOCK_ENABLE, 8'hFF, RESP_OKAY);
    rd(IDX_BLOCK_ENABLE, ENABLE_WRITE_MASK, RESP_OKAY);
    wr(IDX_BLOCK_ENABLE, 8'h00, RESP_OKAY);
    // Low byte lane not strobed: the write is answered but changes nothing
    wr(IDX_BLOCK_ENABLE, 8'hFF, RESP_OKAY, 4'hE);
    rd(IDX_BLOCK_ENABLE, 8'h00, RESP_OKAY);
    // Error counter: random burst, clear on read, saturation
    n = $urandom_range(20, 1);
    @(posedge i_clk);
    fcs_err <= 1'b1;
    repeat (n) @(posedge i_clk);
    fcs_err <= 1'b0;
    rd(IDX_FCS3_COUNT, 8'(n), RESP_OKAY);
    rd(IDX_FCS3_COUNT, 8'h00, RESP_OKAY);
    @(posedge i_clk);
    fcs_err <= 1'b1;
    repeat (300) @(posedge i_clk);
    fcs_err <= 1'b0;
    rd(IDX_FCS3_COUNT, FCS_MAX, RESP_OKAY);
    // Every source: flag shows in its summary bit and clears on its own read
    for (int s = 0; s < SRC_NUM; s++)
      wr(IDX_SRC_ENABLE[s], 8'hFF, RESP_OKAY);
    rd(IDX_SRC_ENABLE[SRC_FRAMER], 8'hFF, RESP_OKAY);
    for (int s = 0; s < SRC_NUM; s++)
    begin
      val = 8'($urandom_range(255, 1));
      @(posedge i_clk);
      src_ev[s] <= val;
      @(posedge i_clk);
      src_ev[s] <= 8'h00;
      repeat (2) @(posedge i_clk);
      rd(IDX_SUMMARY, 8'(1 << grp(s)), RESP_OKAY);
      rd(IDX_SRC_STATUS[s], val, RESP_OKAY);
      rd(IDX_SUMMARY, 8'h00, RESP_OKAY);
    end
    // Clock loss needs the detect enable; both sticky bits clear on summary read
    wr(IDX_IRQ_STATUS, 8'hFF, RESP_OKAY);
    wr(IDX_BLOCK_ENABLE, 8'h30, RESP_OKAY);
    pulse(1'b1, 1'b0);
    rd(IDX_SUMMARY, 8'h00, RESP_OKAY);
    wr(IDX_CLK_CFG, 8'h01, RESP_OKAY);
    rd(IDX_CLK_CFG, 8'h01, RESP_OKAY);
    pulse(1'b1, 1'b1);
    rd(IDX_SUMMARY, 8'h30, RESP_OKAY);
    rd(IDX_SUMMARY, 8'h00, RESP_OKAY);
    // Interrupt pin: raised, masked, unmasked, cleared by writing ones
    repeat (3) @(posedge i_clk);
    `CHK("irq", 1'b1, irq)
    rd(IDX_IRQ_STATUS, 8'h30, RESP_OKAY);
    wr(IDX_BLOCK_ENABLE, 8'h00, RESP_OKAY);
    repeat (3) @(posedge i_clk);
    `CHK("irq", 1'b0, irq)
    wr(IDX_BLOCK_ENABLE, 8'h20, RESP_OKAY);
    repeat (3) @(posedge i_clk);
    `CHK("irq", 1'b1, irq)
    wr(IDX_IRQ_STATUS, 8'h30, RESP_OKAY);
    repeat (3) @(posedge i_clk);
    `CHK("irq", 1'b0, irq)
    rd(IDX_IRQ_STATUS, 8'h00, RESP_OKAY);
    repeat (4) @(posedge i_clk);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
